// [shared/lnab_pkg.sv]
/*
 * shared constants and types of the lin auto-baud, wake and break block:
 * register offsets, field positions, reset values, divider shifts, states.
 * assumes a 32-bit axi4-lite slave with byte-wide registers in the low lane.
 */
package lnab_pkg;
    localparam int CLOCK_HZ = 20_000_000;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_RX_DATA = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA = 8'h14;
    // control register bits
    localparam int CTL_ABD_EN = 0;
    localparam int CTL_WAKE_EN = 1;
    localparam int CTL_SYNC_MODE = 2;
    localparam int CTL_WIDE = 3;
    localparam int CTL_HSPEED = 4;
    localparam int CTL_SEND_BREAK = 5;
    localparam int CTL_TX_EN = 6;
    // status register bits
    localparam int STS_RX_FLAG = 0;
    localparam int STS_TX_FLAG = 1;
    localparam int STS_SR_EMPTY = 2;
    localparam int STS_RX_IDLE = 3;
    localparam int STS_ABD_OVF = 4;
    // base clock = system clock >> shift, for {wide, high speed}
    localparam logic [3:0] SHIFT_00 = 4'h6;
    localparam logic [3:0] SHIFT_01 = 4'h4;
    localparam logic [3:0] SHIFT_10 = 4'h4;
    localparam logic [3:0] SHIFT_11 = 4'h2;
    localparam logic [3:0] ABD_SHIFT = 4'h3;
    localparam logic [2:0] ABD_LAST_RISE = 3'h4;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [15:0] DIV_START = 16'h0001;
    localparam logic [15:0] DIV_MAX = 16'hFFFF;
    localparam logic [3:0] BITS_BYTE = 4'hA;
    localparam logic [3:0] BITS_BREAK = 4'hE;
    localparam logic [13:0] SHIFT_BREAK = 14'h2000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        AB_IDLE, AB_WAIT_WAKE, AB_WAIT_START, AB_WAIT_RISE, AB_COUNT
    } lnab_ab_state_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} lnab_tx_state_t;
endpackage

// [logic/lnab_core.sv]
/*
 * lin extension of the serial transceiver: auto-baud measurement of the sync
 * byte into the divisor pair, wake on break, break transmission, axi4-lite
 * registers. assumes i_rx_line is an unsynchronised pin and that the normal
 * receiver outside obeys o_rx_hold.
 */
// Local design decisions: the register addresses and the AXI4-Lite register port.
// Operation
// R1: setting auto-baud enable starts calibration; receiver held idle throughout.
// R2: counting starts at first rise after start bit, stops at fifth rise.
// R3: fifth rise leaves count in divisor, clears enable, sets receive flag.
// R4: reading receive data clears receive flag; software discards the value.
// R5: divisor pair counts as one 16-bit counter, ignoring wide select.
// R6: counter ticks at one eighth of the selected baud base clock.
// R7: counter starts at one; software subtracts one afterwards.
// R8: with wake enable also set, measure the byte after the break.
// R9: overflow flag sets when counter passes 16 bits before fifth rise.
// R10: after overflow keep counting; fifth rise still sets flag, clears enable.
// R11: clearing enable aborts; overflow clears only once enable is clear.
// R12: wake enable holds receiver idle, watching line; async mode only.
// R13: falling receive line is the wake event; sets receive flag.
// R14: rising edge ending break clears wake enable, then idle.
// R15: non-zero character: low time to first rise is the wake event.
// R16: sender starts with all-zero wake character of ten bit times or more.
// R17: software checks receive idle before setting wake enable.
// R18: break is start bit, twelve zero bits, stop bit.
// R19: transmit write with send-break and enable sends a break, data ignored.
// R20: send-break self-clears after break stop bit; preloaded byte follows.
// R21: lin master writes dummy byte, then sync byte when buffer empty.
// R22: wake edge detector runs on system clock, no baud clock needed.
`timescale 1ns/100ps
module lnab_core (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_sleep,
    input wire logic i_rx_line,
    output logic o_tx_line,
    output logic o_rx_hold,
    output logic o_wake_request,
    output logic o_receive_interrupt_flag,
    output logic o_transmit_interrupt_flag,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [lnab_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [lnab_pkg::ADDR_W-1:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp
);
    import lnab_pkg::*;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic rx_f;
        logic rx_prev;
        logic abd_en;
        logic wake_en;
        logic sync_mode;
        logic wide;
        logic hspeed;
        logic send_break;
        logic tx_en;
        logic rx_flag;
        logic abd_ovf;
        logic wake_fell;
        logic [15:0] divisor;
        lnab_ab_state_t ab_state;
        logic [2:0] ab_rises;
        logic [9:0] ab_pre;
        lnab_tx_state_t tx_state;
        logic [7:0] tx_buf;
        logic tx_buf_valid;
        logic tx_buf_break;
        logic [13:0] tx_shift;
        logic [3:0] tx_bits;
        logic tx_is_break;
        logic [22:0] tx_cyc;
        logic tx_line;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } lnab_state_t;

    localparam lnab_state_t ST_RESET = '{
        rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1, rx_f: 1'b1, rx_prev: 1'b1,
        divisor: DIV_RESET, ab_state: AB_IDLE, tx_state: TX_IDLE,
        tx_line: 1'b1, default: '0};

    lnab_state_t st_reg;
    lnab_state_t st_next;
    logic rx_fall;
    logic rx_rise;
    logic [3:0] base_shift;
    logic [22:0] bit_len;
    logic [9:0] abd_lim;
    logic abd_tick;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [7:0] ar_addr;
    logic ar_take;
    logic rd_rx;
    logic break_claimed;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic ab_done;
    logic rx_idle;

    // edges from the filtered line; the first sync flop feeds only the second
    assign rx_fall = st_reg.rx_prev & ~st_reg.rx_f;
    assign rx_rise = ~st_reg.rx_prev & st_reg.rx_f;
    assign wr_go = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    assign wr_addr = {st_reg.aw_addr[7:2], 2'b00};
    assign ar_addr = {i_s_axi_araddr[7:2], 2'b00};
    assign ar_take = i_s_axi_arvalid & ~st_reg.rvalid;
    // R4 read clears flag
    assign rd_rx = ar_take & (ar_addr == ADDR_RX_DATA);
    assign break_claimed = (st_reg.tx_state == TX_SHIFT) & st_reg.tx_is_break;
    assign ab_done = (st_reg.ab_state == AB_COUNT) & rx_rise
        & (st_reg.ab_rises == ABD_LAST_RISE);
    // receive idle: no measured frame and no wake break under way
    assign rx_idle = (st_reg.ab_state != AB_WAIT_RISE)
        & (st_reg.ab_state != AB_COUNT) & ~st_reg.wake_fell;

    // base clock divider select and bit length of the transmitter
    always_comb begin
        unique case ({st_reg.wide, st_reg.hspeed})
            2'b00: base_shift = SHIFT_00;
            2'b01: base_shift = SHIFT_01;
            2'b10: base_shift = SHIFT_10;
            2'b11: base_shift = SHIFT_11;
        endcase
    end
    assign bit_len = ({7'h00, st_reg.divisor} + 23'h00_0001) << base_shift;
    // R6 eighth of base
    assign abd_lim = (10'h001 << (base_shift + ABD_SHIFT)) - 10'h001;
    // baud clocks stand still in sleep
    assign abd_tick = (st_reg.ab_pre == abd_lim) & ~i_sleep;

    // register read mux; unmapped offsets answer slverr with zero data
    always_comb begin
        rd_byte = BYTE_ZERO;
        rd_hit = 1'b1;
        unique case (ar_addr)
            ADDR_CONTROL: begin
                rd_byte[CTL_ABD_EN] = st_reg.abd_en;
                rd_byte[CTL_WAKE_EN] = st_reg.wake_en;
                rd_byte[CTL_SYNC_MODE] = st_reg.sync_mode;
                rd_byte[CTL_WIDE] = st_reg.wide;
                rd_byte[CTL_HSPEED] = st_reg.hspeed;
                rd_byte[CTL_SEND_BREAK] = st_reg.send_break;
                rd_byte[CTL_TX_EN] = st_reg.tx_en;
            end
            ADDR_STATUS: begin
                rd_byte[STS_RX_FLAG] = st_reg.rx_flag;
                rd_byte[STS_TX_FLAG] = ~st_reg.tx_buf_valid;
                rd_byte[STS_SR_EMPTY] = st_reg.tx_state == TX_IDLE;
                rd_byte[STS_RX_IDLE] = rx_idle;
                rd_byte[STS_ABD_OVF] = st_reg.abd_ovf;
            end
            ADDR_DIV_LOW: rd_byte = st_reg.divisor[7:0];
            ADDR_DIV_HIGH: rd_byte = st_reg.divisor[15:8];
            // normal framing lives outside; this byte reads as zero
            ADDR_RX_DATA: rd_byte = BYTE_ZERO;
            ADDR_TX_DATA: rd_byte = BYTE_ZERO;
            default: rd_hit = 1'b0;
        endcase
    end

    // next state: software effects first, hardware events after so sets win
    always_comb begin
        st_next = st_reg;
        // pin input: three flops, level taken when the last two agree
        st_next.rx_s1 = i_rx_line;
        st_next.rx_s2 = st_reg.rx_s1;
        st_next.rx_s3 = st_reg.rx_s2;
        if (st_reg.rx_s2 == st_reg.rx_s3) begin
            st_next.rx_f = st_reg.rx_s3;
        end
        st_next.rx_prev = st_reg.rx_f;

        // axi write channels, taken in either order
        if (i_s_axi_awvalid & ~st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid & ~st_reg.w_held) begin
            st_next.w_held = 1'b1;
            st_next.w_data = i_s_axi_wdata[7:0];
            st_next.w_lane0 = i_s_axi_wstrb[0];
        end
        if (st_reg.bvalid & i_s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (wr_addr)
                ADDR_CONTROL, ADDR_STATUS, ADDR_DIV_LOW, ADDR_DIV_HIGH,
                ADDR_RX_DATA, ADDR_TX_DATA: st_next.bresp = RESP_OKAY;
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        if (wr_go & st_reg.w_lane0) begin
            unique case (wr_addr)
                ADDR_CONTROL: begin
                    // R1 enable starts calibration
                    st_next.abd_en = st_reg.w_data[CTL_ABD_EN];
                    st_next.wake_en = st_reg.w_data[CTL_WAKE_EN];
                    st_next.sync_mode = st_reg.w_data[CTL_SYNC_MODE];
                    st_next.wide = st_reg.w_data[CTL_WIDE];
                    st_next.hspeed = st_reg.w_data[CTL_HSPEED];
                    st_next.send_break = st_reg.w_data[CTL_SEND_BREAK];
                    st_next.tx_en = st_reg.w_data[CTL_TX_EN];
                end
                ADDR_STATUS: begin
                    // R11 overflow sticks while enabled
                    if (st_reg.w_data[STS_ABD_OVF] & ~st_reg.abd_en) begin
                        st_next.abd_ovf = 1'b0;
                    end
                end
                ADDR_DIV_LOW: st_next.divisor[7:0] = st_reg.w_data;
                ADDR_DIV_HIGH: st_next.divisor[15:8] = st_reg.w_data;
                ADDR_TX_DATA: begin
                    // R19 break on data write
                    if (st_reg.tx_en & ~st_reg.tx_buf_valid) begin
                        st_next.tx_buf = st_reg.w_data;
                        st_next.tx_buf_valid = 1'b1;
                        st_next.tx_buf_break = st_reg.send_break & ~break_claimed;
                    end
                end
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end

        // axi read channel, answered one cycle after the address is taken
        if (st_reg.rvalid & i_s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_byte;
            st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rd_rx) begin
            st_next.rx_flag = 1'b0;
        end

        // auto-baud sequencer; the divisor pair itself is the counter
        st_next.ab_pre = (st_reg.ab_pre == abd_lim) ? 10'h000
            : st_reg.ab_pre + 10'h001;
        unique case (st_reg.ab_state)
            AB_IDLE: begin
                if (st_reg.abd_en) begin
                    // R8 measure after break
                    st_next.ab_state = st_reg.wake_en ? AB_WAIT_WAKE : AB_WAIT_START;
                end
            end
            AB_WAIT_WAKE: begin
                if (~st_reg.wake_en) begin
                    st_next.ab_state = AB_WAIT_START;
                end
            end
            AB_WAIT_START: begin
                if (rx_fall) begin
                    st_next.ab_state = AB_WAIT_RISE;
                end
            end
            AB_WAIT_RISE: begin
                if (rx_rise) begin
                    // R2 first rise starts
                    // R7 count from one
                    st_next.ab_state = AB_COUNT;
                    st_next.divisor = DIV_START;
                    st_next.ab_rises = 3'h1;
                    st_next.ab_pre = 10'h000;
                end
            end
            AB_COUNT: begin
                if (ab_done) begin
                    // R3 result and flag
                    // R10 done despite overflow
                    st_next.ab_state = AB_IDLE;
                    st_next.abd_en = 1'b0;
                    st_next.rx_flag = 1'b1;
                end else begin
                    if (rx_rise) begin
                        st_next.ab_rises = st_reg.ab_rises + 3'h1;
                    end
                    if (abd_tick) begin
                        // R5 one 16-bit counter
                        st_next.divisor = st_reg.divisor + 16'h0001;
                        // R9 overflow past 16 bits
                        if (st_reg.divisor == DIV_MAX) begin
                            st_next.abd_ovf = 1'b1;
                        end
                    end
                end
            end
            default: st_next.ab_state = AB_IDLE;
        endcase
        // R11 clearing enable aborts
        if (~st_next.abd_en) begin
            st_next.ab_state = AB_IDLE;
        end

        // wake on break, only in asynchronous mode
        if (st_reg.wake_en & ~st_reg.sync_mode) begin
            // R13 falling edge wakes
            // R15 low time is the event
            if (rx_fall & ~st_reg.wake_fell) begin
                st_next.wake_fell = 1'b1;
                st_next.rx_flag = 1'b1;
            end
            // R14 rise ends break
            if (rx_rise & st_reg.wake_fell) begin
                st_next.wake_en = 1'b0;
                st_next.wake_fell = 1'b0;
            end
        end
        if (~st_next.wake_en) begin
            st_next.wake_fell = 1'b0;
        end

        // transmitter: one buffered byte ahead of the shift register
        unique case (st_reg.tx_state)
            TX_IDLE: begin
                if (st_reg.tx_buf_valid & st_reg.tx_en) begin
                    st_next.tx_state = TX_SHIFT;
                    st_next.tx_buf_valid = 1'b0;
                    st_next.tx_is_break = st_reg.tx_buf_break;
                    st_next.tx_cyc = 23'h00_0000;
                    // R18 start, twelve zeros, stop
                    if (st_reg.tx_buf_break) begin
                        st_next.tx_shift = SHIFT_BREAK;
                        st_next.tx_bits = BITS_BREAK;
                    end else begin
                        st_next.tx_shift = {5'h1F, st_reg.tx_buf, 1'b0};
                        st_next.tx_bits = BITS_BYTE;
                    end
                end
            end
            TX_SHIFT: begin
                if (~i_sleep) begin
                    st_next.tx_cyc = st_reg.tx_cyc + 23'h00_0001;
                end
                // bit timer frozen in sleep, so no shift may happen either
                if (~i_sleep && (st_reg.tx_cyc == bit_len - 23'h00_0001)) begin
                    st_next.tx_cyc = 23'h00_0000;
                    st_next.tx_shift = {1'b1, st_reg.tx_shift[13:1]};
                    st_next.tx_bits = st_reg.tx_bits - 4'h1;
                    if (st_reg.tx_bits == 4'h1) begin
                        st_next.tx_state = TX_IDLE;
                        // R20 self-clearing send-break
                        if (st_reg.tx_is_break) begin
                            st_next.send_break = 1'b0;
                        end
                    end
                end
            end
        endcase
        st_next.tx_line = (st_next.tx_state == TX_SHIFT) ? st_next.tx_shift[0] : 1'b1;
    end

    // single state register
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // R1 receiver held idle
    // R12 wake holds receiver
    assign o_rx_hold = st_reg.abd_en | (st_reg.wake_en & ~st_reg.sync_mode);
    // R22 wake request comes straight from the pin; its edge detector runs on the system clock, which sleep does not stop
    assign o_wake_request = st_reg.wake_en & ~st_reg.sync_mode & ~st_reg.wake_fell
        & ~i_rx_line;
    assign o_tx_line = st_reg.tx_line;
    assign o_receive_interrupt_flag = st_reg.rx_flag;
    assign o_transmit_interrupt_flag = ~st_reg.tx_buf_valid;
    assign o_s_axi_awready = ~st_reg.aw_held;
    assign o_s_axi_wready = ~st_reg.w_held;
    assign o_s_axi_bvalid = st_reg.bvalid;
    assign o_s_axi_bresp = st_reg.bresp;
    assign o_s_axi_arready = ~st_reg.rvalid;
    assign o_s_axi_rvalid = st_reg.rvalid;
    assign o_s_axi_rdata = {24'h00_0000, st_reg.rdata};
    assign o_s_axi_rresp = st_reg.rresp;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    property p_hold_abd;
        st_reg.ab_state != AB_IDLE |-> o_rx_hold;
    endproperty
    a_hold_abd: assert property (p_hold_abd) else $error("receiver not held"); // R1

    property p_start_one;
        st_reg.ab_state == AB_WAIT_RISE && rx_rise && st_reg.abd_en
            && !(wr_go && st_reg.w_lane0 && wr_addr == ADDR_CONTROL)
            |=> st_reg.ab_state == AB_COUNT && st_reg.divisor == DIV_START;
    endproperty
    a_start_one: assert property (p_start_one) else $error("count not from one"); // R7

    property p_done;
        ab_done |=> !st_reg.abd_en && st_reg.rx_flag && st_reg.ab_state == AB_IDLE
            && st_reg.divisor == $past(st_reg.divisor);
    endproperty
    a_done: assert property (p_done) else $error("auto-baud end wrong"); // R3

    property p_overflow;
        st_reg.ab_state == AB_COUNT && !ab_done && abd_tick
            && st_reg.divisor == DIV_MAX |=> st_reg.abd_ovf && st_reg.divisor == DIV_RESET;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed"); // R9

    property p_ovf_sticky;
        st_reg.abd_ovf && st_reg.abd_en |=> st_reg.abd_ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost"); // R11

    property p_rd_clear;
        rd_rx && !ab_done && !(rx_fall && st_reg.wake_en) |=> !st_reg.rx_flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flag not cleared"); // R4

    property p_wake_flag;
        st_reg.wake_en && !st_reg.sync_mode && rx_fall && !st_reg.wake_fell
            |=> st_reg.rx_flag && st_reg.wake_fell;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake event missed"); // R13

    property p_wake_end;
        st_reg.wake_en && !st_reg.sync_mode && st_reg.wake_fell && rx_rise
            |=> !st_reg.wake_en;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("wake not cleared"); // R14

    property p_break_low;
        st_reg.tx_state == TX_SHIFT && st_reg.tx_is_break
            && st_reg.tx_bits > 4'h1 |-> !o_tx_line;
    endproperty
    a_break_low: assert property (p_break_low) else $error("break not low"); // R18

    property p_sb_clear;
        st_reg.tx_state == TX_SHIFT && st_reg.tx_is_break && st_reg.tx_bits == 4'h1
            && st_reg.tx_cyc == bit_len - 23'h00_0001 && !i_sleep
            |=> !st_reg.send_break && o_tx_line;
    endproperty
    a_sb_clear: assert property (p_sb_clear) else $error("send-break kept"); // R20

    c_abd_done: cover property (ab_done);
    c_abd_ovf: cover property (ab_done && st_reg.abd_ovf);
    c_wake: cover property (st_reg.wake_fell && rx_rise);
    c_break_sent: cover property (st_reg.tx_is_break && st_reg.tx_state == TX_SHIFT
        ##1 st_reg.tx_state == TX_IDLE);
endmodule // lnab_core

// [sim/lnab_node.sv]
/* remote serial node that drives the receive pin of the block.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/100ps
module lnab_node (
    input wire logic i_clock,
    output logic o_line
);
    initial o_line = 1'b1;
    // hold a level n clocks, wake char
    task automatic level(input logic v, input int n);
        o_line <= v;
        repeat (n) @(posedge i_clock);
    endtask
    // start bit, lsb first, then stop bit
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) level(f[i], bt);
    endtask
endmodule // lnab_node

// [sim/lnab_core_tb.sv]
/* bench of the lin auto-baud, wake and break block.
   assumes the node model drives the receive pin; ready lines tied high. */
`timescale 1ns/100ps
module lnab_core_tb;
    import lnab_pkg::*;
    logic i_clock, i_reset, aw, w, ar, awr, wr, bv, arr, rv, tx, hold, rxf, rx;
    logic [7:0] aa, ra;
    logic [31:0] wd, rd, got;
    logic [1:0] br, rr, gr;
    logic slp, txf, wk;
    logic tp = 1'b1;
    int fail_count = 0, n_tests = 0, nf = 0, lo = 0, run = 0;
    lnab_core lnab_core_i (.i_clock, .i_reset, .i_sleep(slp), .i_rx_line(rx),
        .o_tx_line(tx), .o_rx_hold(hold), .o_wake_request(wk),
        .o_receive_interrupt_flag(rxf), .o_transmit_interrupt_flag(txf),
        .i_s_axi_awvalid(aw), .o_s_axi_awready(awr), .i_s_axi_awaddr(aa),
        .i_s_axi_wvalid(w), .o_s_axi_wready(wr), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(1'b1),
        .o_s_axi_bresp(br), .i_s_axi_arvalid(ar), .o_s_axi_arready(arr),
        .i_s_axi_araddr(ra), .o_s_axi_rvalid(rv), .i_s_axi_rready(1'b1),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(rr));
    lnab_node lnab_node_i (.i_clock(i_clock), .o_line(rx));
    // clock of 50 ns
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // tx falls and longest low run, since a break overlaps the bus writes
    always @(posedge i_clock) begin
        tp <= tx;
        if (tp === 1'b1 && tx === 1'b0) nf <= nf + 1;
        lo <= (tx === 1'b0) ? lo + 1 : 0;
        if (lo > run) run <= lo;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // address and data offered together, each released once taken
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bit ta = 1'b0;
        bit tw = 1'b0;
        aa <= a;
        wd <= d;
        aw <= 1'b1;
        w <= 1'b1;
        forever begin
            @(posedge i_clock);
            // lower each valid once only, so a next call may raise it cleanly
            if (awr && !ta) begin
                aw <= 1'b0;
                ta = 1'b1;
            end
            if (wr && !tw) begin
                w <= 1'b0;
                tw = 1'b1;
            end
            if (bv) break;
        end
        gr = br;
    endtask
    task automatic rreg(input logic [7:0] a);
        ra <= a;
        ar <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (arr) ar <= 1'b0;
            if (rv) break;
        end
        got = rd;
        gr = rr;
    endtask
    task automatic s_abd;
        rreg(8'h18);
        chk(gr, RESP_SLVERR);
        wreg(ADDR_CONTROL, 32'h0000_0019);
        chk(gr, RESP_OKAY);
        chk(hold, 1'b1);
        lnab_node_i.send(8'h55, 64);
        cyc(10);
        rreg(ADDR_DIV_LOW);
        chk(got > 32'h0000_000F && got < 32'h0000_0013, 1'b1);
        rreg(ADDR_DIV_HIGH);
        chk(got, 32'h0000_0000);
        rreg(ADDR_CONTROL);
        chk(got[CTL_ABD_EN], 1'b0);
        chk(rxf, 1'b1);
        rreg(ADDR_RX_DATA);
        chk(rxf, 1'b0);
    endtask
    task automatic s_break;
        wreg(ADDR_DIV_LOW, 32'h0000_0000);
        wreg(ADDR_CONTROL, 32'h0000_0078);
        // dummy then sync byte
        wreg(ADDR_TX_DATA, 32'h0000_00FF);
        wreg(ADDR_TX_DATA, 32'h0000_0055);
        cyc(120);
        chk(run, 52);
        chk(nf, 6);
        chk(txf, 1'b1);
        rreg(ADDR_CONTROL);
        chk(got[CTL_SEND_BREAK], 1'b0);
        rreg(ADDR_STATUS);
        chk(got[STS_SR_EMPTY], 1'b1);
    endtask
    task automatic s_wake;
        rreg(ADDR_STATUS);
        chk(got[STS_RX_IDLE], 1'b1);
        wreg(ADDR_CONTROL, 32'h0000_0002);
        chk(hold, 1'b1);
        // asleep: the break edge must still be caught
        slp <= 1'b1;
        lnab_node_i.level(1'b0, 1);
        chk(wk, 1'b1);
        lnab_node_i.level(1'b0, 19);
        chk(rxf, 1'b1);
        chk(wk, 1'b0);
        lnab_node_i.level(1'b1, 20);
        slp <= 1'b0;
        rreg(ADDR_CONTROL);
        chk(got[CTL_WAKE_EN], 1'b0);
        rreg(ADDR_RX_DATA);
        // wake with auto-baud: break first, then the sync byte is measured
        wreg(ADDR_CONTROL, 32'h0000_001B);
        lnab_node_i.level(1'b0, 40);
        lnab_node_i.level(1'b1, 16);
        lnab_node_i.send(8'h55, 64);
        cyc(10);
        rreg(ADDR_DIV_LOW);
        chk(got > 32'h0000_000F && got < 32'h0000_0013, 1'b1);
        rreg(ADDR_CONTROL);
        chk(got[1:0], 2'b00);
    endtask
    task automatic close_out;
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard, well beyond the expected run of about 1600 cycles
    initial begin
        cyc(6000);
        fail_count++;
        close_out;
    end
    initial begin
        i_reset = 1'b1;
        {aw, w, ar, aa, ra, wd, slp} = '0;
        cyc(5);
        i_reset <= 1'b0;
        cyc(1);
        s_abd;
        s_break;
        s_wake;
        close_out;
    end
endmodule // lnab_core_tb
